/* hw/fswsq_top.sv */
// Flash self-write sequencer: unlock, four-word buffer, row erase and program.
// Assumes a byte register port with read data one cycle after the read strobe.
//
// The placing of the registers and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
// Operation
// - Never alter write-protected segments
// - Blocks are four aligned words
// - Commit erases row then programs buffer
// - Unlock 55h then AAh, then start
// - First three words only fill buffer
// - Last word triggers erase and program
// - Two setup cycles after start
// - Core stalls during erase, clocks run
// - Core resumes after programming completes
// - Write enable cleared, power-up timer blocks
// - Start needs write enable and unlock
// - Self-write data stays unscrambled
// - Serial port denied protected segments
// - Start bit only set, hardware clears
// - Write enable gates program and erase
// - Unlock register stores nothing, reads zero
// - Ten-bit address, fourteen-bit data words
module fswsq_top
  #(
  parameter int unsigned P_ERASE_CYC = fswsq_pkg::ERASE_CYC,
  parameter int unsigned P_PWRT_CYC  = fswsq_pkg::PWRT_CYC
) (
  input  wire logic                         i_clk,
  input  wire logic                         i_rstn,
  input  wire logic                         i_ce,
  input  wire logic [2:0]                   i_reg_addr,
  input  wire logic [7:0]                   i_reg_wdata,
  input  wire logic                         i_reg_wr,
  input  wire logic                         i_reg_rd,
  output logic      [7:0]                   o_reg_rdata,
  input  wire logic [1:0]                   i_wrt_cfg,
  input  wire logic [fswsq_pkg::ADDR_W-1:0] i_serial_addr,
  output logic                              o_serial_wr_allow,
  output logic                              o_core_stall,
  output logic                              o_busy,
  output logic                              o_fl_erase,
  output logic                              o_fl_prog,
  output logic      [fswsq_pkg::ADDR_W-1:0] o_fl_addr,
  output logic      [fswsq_pkg::DATA_W-1:0] o_fl_data
);
  import fswsq_pkg::*;

  // ****************************************************************
  // Reset release
  // ****************************************************************
  logic [1:0] rst_sync_ff;
  logic       rstn_s;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end

  assign rstn_s = rst_sync_ff[1];

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [7:0]             addr_low_ff;
  logic [ADDR_HIGH_W-1:0] addr_high_ff;
  logic [7:0]             data_low_ff;
  logic [DATA_HIGH_W-1:0] data_high_ff;
  logic                   write_enable_bit_ff;
  logic                   wr_ff;
  fswsq_unl_t             unl_ff;
  fswsq_unl_t             nxt_unl;
  fswsq_seq_t             seq_ff;
  fswsq_seq_t             nxt_seq;
  logic [DATA_W-1:0]      buf_ff [BLK_WORDS];
  logic [IDX_W-1:0]       idx_ff;
  logic [IDX_W-1:0]       nxt_idx;
  logic [1:0]             setup_cnt_ff;
  logic [1:0]             nxt_setup_cnt;
  logic [7:0]             rdata_ff;
  logic [7:0]             nxt_rdata;
  logic                   fl_erase_ff;
  logic                   fl_prog_ff;
  logic [ADDR_W-1:0]      fl_addr_ff;
  logic [DATA_W-1:0]      fl_data_ff;
  logic [ADDR_W-1:0]      nxt_fl_addr;
  logic                   nxt_wr;

  logic              wr_ctrl;
  logic              wr_unlock;
  logic              wr_addr_low;
  logic              wr_addr_high;
  logic              wr_data_low;
  logic              wr_data_high;
  logic              start_try;
  logic              start_ok;
  logic              pwrt_busy;
  logic              erase_last;
  logic              erase_load;
  logic              setup_end;
  logic              prog_end;
  logic              done;
  logic              last_word;
  logic              blk_protected;
  logic              serial_protected;
  logic [ADDR_W-1:0] cur_addr;
  logic [DATA_W-1:0] cur_data;
  logic [7:0]        ctrl_view;
  logic [7:0]        rd_mux;

  // ****************************************************************
  // Register decode
  // ****************************************************************
  assign wr_ctrl      = i_reg_wr && (i_reg_addr == REG_CONTROL);
  assign wr_unlock    = i_reg_wr && (i_reg_addr == REG_UNLOCK);
  assign wr_addr_low  = i_reg_wr && (i_reg_addr == REG_ADDR_LOW);
  assign wr_addr_high = i_reg_wr && (i_reg_addr == REG_ADDR_HIGH);
  assign wr_data_low  = i_reg_wr && (i_reg_addr == REG_DATA_LOW);
  assign wr_data_high = i_reg_wr && (i_reg_addr == REG_DATA_HIGH);

  assign cur_addr = {addr_high_ff, addr_low_ff};
  assign cur_data = {data_high_ff, data_low_ff};

  // ****************************************************************
  // Write protection
  // ****************************************************************
  // Segments start at word zero, so one compare per setting
  assign blk_protected    = (i_wrt_cfg == WRT_ALL) ||
                            ((i_wrt_cfg == WRT_HALF) && (cur_addr < HALF_END)) ||
                            ((i_wrt_cfg == WRT_QUARTER) && (cur_addr < QUARTER_END));
  assign serial_protected = (i_wrt_cfg == WRT_ALL) ||
                            ((i_wrt_cfg == WRT_HALF) && (i_serial_addr < HALF_END)) ||
                            ((i_wrt_cfg == WRT_QUARTER) && (i_serial_addr < QUARTER_END));
  // Serial port writes are allowed only outside the protected segment
  assign o_serial_wr_allow = !serial_protected;

  // ****************************************************************
  // Start qualification
  // ****************************************************************
  assign start_try = wr_ctrl && i_reg_wdata[CTRL_WR_BIT] && (seq_ff == SEQ_IDLE);
  assign start_ok  = start_try && (unl_ff == UNL_ARMED) && write_enable_bit_ff && !pwrt_busy;
  assign last_word = (addr_low_ff[1:0] == LAST_IN_BLOCK);

  // ****************************************************************
  // Unlock sequence
  // ****************************************************************
  always_comb begin
    nxt_unl = unl_ff;
    if (wr_unlock) begin
      unique case (unl_ff)
        UNL_LOCKED: begin
          nxt_unl = (i_reg_wdata == UNLOCK_FIRST) ? UNL_FIRST : UNL_LOCKED;
        end
        UNL_FIRST: begin
          nxt_unl = (i_reg_wdata == UNLOCK_SECOND) ? UNL_ARMED : UNL_LOCKED;
        end
        UNL_ARMED: begin
          nxt_unl = UNL_LOCKED;
        end
        default: begin
          nxt_unl = UNL_LOCKED;
        end
      endcase
    end else if (start_try) begin
      // Each start written in idle spends the unlock, armed or not
      nxt_unl = UNL_LOCKED;
    end
  end

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  assign setup_end  = (seq_ff == SEQ_SETUP) && (setup_cnt_ff == 2'(SETUP_CYC - 1));
  assign erase_load = setup_end && last_word && !blk_protected;
  assign prog_end   = (seq_ff == SEQ_PROG) && (idx_ff == IDX_W'(BLK_WORDS - 1));
  assign done       = (setup_end && !erase_load) || prog_end;

  always_comb begin
    nxt_seq       = seq_ff;
    nxt_idx       = idx_ff;
    nxt_setup_cnt = setup_cnt_ff;
    unique case (seq_ff)
      SEQ_IDLE: begin
        if (start_ok) begin
          nxt_seq       = SEQ_SETUP;
          nxt_setup_cnt = 2'h0;
        end
      end
      SEQ_SETUP: begin
        nxt_setup_cnt = setup_cnt_ff + 2'h1;
        if (erase_load) begin
          nxt_seq = SEQ_ERASE;
        end else if (setup_end) begin
          nxt_seq = SEQ_IDLE;
        end
      end
      SEQ_ERASE: begin
        if (erase_last) begin
          nxt_seq = SEQ_PROG;
          nxt_idx = '0;
        end
      end
      SEQ_PROG: begin
        nxt_idx = idx_ff + IDX_W'(1);
        if (prog_end) begin
          nxt_seq = SEQ_IDLE;
        end
      end
      default: begin
        nxt_seq = SEQ_IDLE;
      end
    endcase
  end

  // Start bit: software can only set it, completion clears it
  assign nxt_wr = start_ok ? 1'b1 : (done ? 1'b0 : wr_ff);

  // ****************************************************************
  // Flash array drive
  // ****************************************************************
  // Erase addresses the sixteen-word row, program walks the block
  assign nxt_fl_addr = (nxt_seq == SEQ_ERASE) ? {cur_addr[ADDR_W-1:4], ROW_BASE_LOW} :
                       (nxt_seq == SEQ_PROG) ? {cur_addr[ADDR_W-1:IDX_W], nxt_idx} :
                       fl_addr_ff;

  always_ff @(posedge i_clk or negedge rstn_s) begin
    if (!rstn_s) begin
      fl_erase_ff <= 1'b0;
      fl_prog_ff  <= 1'b0;
      fl_addr_ff  <= '0;
      fl_data_ff  <= '0;
    end else if (i_ce) begin
      fl_erase_ff <= (nxt_seq == SEQ_ERASE) && write_enable_bit_ff;
      fl_prog_ff  <= (nxt_seq == SEQ_PROG) && write_enable_bit_ff;
      fl_addr_ff  <= nxt_fl_addr;
      // Buffer words go out as written, no scrambling
      fl_data_ff  <= buf_ff[nxt_idx];
    end
  end

  assign o_fl_erase = fl_erase_ff;
  assign o_fl_prog  = fl_prog_ff;
  assign o_fl_addr  = fl_addr_ff;
  assign o_fl_data  = fl_data_ff;
  // Peripherals keep their clock; only instruction fetch is held
  assign o_core_stall = (seq_ff == SEQ_ERASE) || (seq_ff == SEQ_PROG);
  assign o_busy       = wr_ff;

  // ****************************************************************
  // Timers
  // ****************************************************************
  fswsq_timer #(
    .W       (CNT_W),
    .RST_VAL (P_PWRT_CYC)
  ) u_pwrt (
    .i_clk      (i_clk),
    .i_rstn     (rstn_s),
    .i_ce       (i_ce),
    .i_load     (1'b0),
    .i_load_val ('0),
    .o_busy     (pwrt_busy),
    .o_last     ()
  );

  fswsq_timer #(
    .W       (CNT_W),
    .RST_VAL (0)
  ) u_erase (
    .i_clk      (i_clk),
    .i_rstn     (rstn_s),
    .i_ce       (i_ce),
    .i_load     (erase_load),
    .i_load_val (CNT_W'(P_ERASE_CYC)),
    .o_busy     (),
    .o_last     (erase_last)
  );

  // ****************************************************************
  // Register file
  // ****************************************************************
  always_ff @(posedge i_clk or negedge rstn_s) begin
    if (!rstn_s) begin
      addr_low_ff  <= RST_BYTE;
      addr_high_ff <= '0;
      data_low_ff  <= RST_BYTE;
      data_high_ff <= '0;
      write_enable_bit_ff      <= 1'b0;
    end else if (i_ce) begin
      if (wr_addr_low) begin
        addr_low_ff <= i_reg_wdata;
      end
      if (wr_addr_high) begin
        addr_high_ff <= i_reg_wdata[ADDR_HIGH_W-1:0];
      end
      if (wr_data_low) begin
        data_low_ff <= i_reg_wdata;
      end
      if (wr_data_high) begin
        data_high_ff <= i_reg_wdata[DATA_HIGH_W-1:0];
      end
      if (wr_ctrl) begin
        write_enable_bit_ff <= i_reg_wdata[CTRL_WRITE_ENABLE_BIT_BIT];
      end
    end
  end

  always_ff @(posedge i_clk or negedge rstn_s) begin
    if (!rstn_s) begin
      wr_ff        <= 1'b0;
      unl_ff       <= UNL_LOCKED;
      seq_ff       <= SEQ_IDLE;
      idx_ff       <= '0;
      setup_cnt_ff <= 2'h0;
    end else if (i_ce) begin
      wr_ff        <= nxt_wr;
      unl_ff       <= nxt_unl;
      seq_ff       <= nxt_seq;
      idx_ff       <= nxt_idx;
      setup_cnt_ff <= nxt_setup_cnt;
    end
  end

  // Slot follows the low address bits, so ascending order fills 0..3
  always_ff @(posedge i_clk or negedge rstn_s) begin
    if (!rstn_s) begin
      for (int k = 0; k < BLK_WORDS; k++) begin
        buf_ff[k] <= '0;
      end
    end else if (i_ce && start_ok) begin
      buf_ff[addr_low_ff[IDX_W-1:0]] <= cur_data;
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  assign ctrl_view = {5'h00, write_enable_bit_ff, wr_ff, 1'b0};

  // Unmapped offsets and the unlock register read as zero
  assign rd_mux = (i_reg_addr == REG_CONTROL)   ? ctrl_view :
                  (i_reg_addr == REG_ADDR_LOW)  ? addr_low_ff :
                  (i_reg_addr == REG_ADDR_HIGH) ? {6'h00, addr_high_ff} :
                  (i_reg_addr == REG_DATA_LOW)  ? data_low_ff :
                  (i_reg_addr == REG_DATA_HIGH) ? {2'h0, data_high_ff} :
                  RST_BYTE;

  assign nxt_rdata = i_reg_rd ? rd_mux : RST_BYTE;

  always_ff @(posedge i_clk or negedge rstn_s) begin
    if (!rstn_s) begin
      rdata_ff <= RST_BYTE;
    end else if (i_ce) begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign o_reg_rdata = rdata_ff;

endmodule : fswsq_top

/* hw/fswsq_pkg.sv */
// Constants, register map and state types of the flash self-write sequencer.
// Assumes a 25 MHz system clock and a 3-bit byte register port.
package fswsq_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [2:0] REG_CONTROL   = 3'h0;
  localparam logic [2:0] REG_UNLOCK    = 3'h1;
  localparam logic [2:0] REG_ADDR_LOW  = 3'h2;
  localparam logic [2:0] REG_ADDR_HIGH = 3'h3;
  localparam logic [2:0] REG_DATA_LOW  = 3'h4;
  localparam logic [2:0] REG_DATA_HIGH = 3'h5;

  // ****************************************************************
  // Fields and reset values
  // ****************************************************************
  localparam int         CTRL_WRITE_ENABLE_BIT_BIT  = 2;
  localparam int         CTRL_WR_BIT    = 1;
  localparam int         ADDR_W         = 10;
  localparam int         DATA_W         = 14;
  localparam int         ADDR_HIGH_W    = 2;
  localparam int         DATA_HIGH_W    = 6;
  localparam int         BLK_WORDS      = 4;
  localparam int         IDX_W          = 2;
  localparam logic [1:0] LAST_IN_BLOCK  = 2'h3;
  localparam logic [3:0] ROW_BASE_LOW   = 4'h0;
  localparam logic [7:0] RST_BYTE       = 8'h00;
  localparam logic [7:0] UNLOCK_FIRST   = 8'h55;
  localparam logic [7:0] UNLOCK_SECOND  = 8'haa;

  // ****************************************************************
  // Write protect segments
  // ****************************************************************
  localparam logic [1:0]        WRT_ALL     = 2'h0;
  localparam logic [1:0]        WRT_HALF    = 2'h1;
  localparam logic [1:0]        WRT_QUARTER = 2'h2;
  localparam logic [ADDR_W-1:0] HALF_END    = 10'h200;
  localparam logic [ADDR_W-1:0] QUARTER_END = 10'h100;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam longint CLK_HZ    = 25000000;
  localparam longint ERASE_MS  = 4;
  localparam longint PWRT_MS   = 64;
  localparam int     ERASE_CYC = int'((ERASE_MS * CLK_HZ) / 1000);
  localparam int     PWRT_CYC  = int'((PWRT_MS * CLK_HZ) / 1000);
  localparam int     SETUP_CYC = 2;
  localparam int     CNT_W     = 21;

  // ****************************************************************
  // States
  // ****************************************************************
  typedef enum logic [3:0] {
    SEQ_IDLE  = 4'h1,
    SEQ_SETUP = 4'h2,
    SEQ_ERASE = 4'h4,
    SEQ_PROG  = 4'h8
  } fswsq_seq_t;

  typedef enum logic [2:0] {
    UNL_LOCKED = 3'h1,
    UNL_FIRST  = 3'h2,
    UNL_ARMED  = 3'h4
  } fswsq_unl_t;

endpackage : fswsq_pkg

/* hw/fswsq_timer.sv */
// Loadable down counter used for the power-up hold-off and the erase time.
// Assumes the caller gives a synchronised active-low reset.
`timescale 1ns/1ps
module fswsq_timer #(
  parameter int unsigned W       = 21,
  parameter int unsigned RST_VAL = 0
) (
  input  wire logic         i_clk,
  input  wire logic         i_rstn,
  input  wire logic         i_ce,
  input  wire logic         i_load,
  input  wire logic [W-1:0] i_load_val,
  output logic              o_busy,
  output logic              o_last
);

  logic [W-1:0] cnt_ff;
  logic [W-1:0] nxt_cnt;

  assign o_busy  = (cnt_ff != '0);
  assign o_last  = (cnt_ff == W'(1));
  assign nxt_cnt = i_load ? i_load_val : (o_busy ? cnt_ff - W'(1) : cnt_ff);

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt_ff <= W'(RST_VAL);
    end else if (i_ce) begin
      cnt_ff <= nxt_cnt;
    end
  end

endmodule : fswsq_timer

/* verification/fswsq_chk.sv */
// Port checker of the flash self-write sequencer.
// Assumes it is bound onto fswsq_top and handed the same erase count.
`timescale 1ns/1ps
module fswsq_chk #(
  parameter int unsigned P_ERASE_CYC = 5
) (
  input wire logic                         i_clk,
  input wire logic                         i_rstn,
  input wire logic [2:0]                   i_reg_addr,
  input wire logic [7:0]                   i_reg_wdata,
  input wire logic                         i_reg_wr,
  input wire logic                         i_reg_rd,
  input wire logic [7:0]                   o_reg_rdata,
  input wire logic [1:0]                   i_wrt_cfg,
  input wire logic [fswsq_pkg::ADDR_W-1:0] i_serial_addr,
  input wire logic                         o_serial_wr_allow,
  input wire logic                         o_core_stall,
  input wire logic                         o_busy,
  input wire logic                         o_fl_erase,
  input wire logic                         o_fl_prog,
  input wire logic [fswsq_pkg::ADDR_W-1:0] o_fl_addr
);
  import fswsq_pkg::*;
  // ****************************************************************
  // Properties
  // ****************************************************************
  localparam int EM1 = P_ERASE_CYC - 1;
  wire logic exp_allow = (i_wrt_cfg == WRT_ALL) ? 1'b0 :
                         (i_wrt_cfg == WRT_HALF) ? (i_serial_addr >= HALF_END) :
                         (i_wrt_cfg == WRT_QUARTER) ? (i_serial_addr >= QUARTER_END) : 1'b1;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  sequence s_prog_run;
    o_fl_prog && o_fl_addr[1:0] == 2'h0 ##1 o_fl_prog && o_fl_addr[1:0] == 2'h1
    ##1 o_fl_prog && o_fl_addr[1:0] == 2'h2 ##1 o_fl_prog && o_fl_addr[1:0] == 2'h3;
  endsequence
  sequence s_setup;
    (o_busy && !o_core_stall) [*2];
  endsequence
  a_unlock_zero: assert property ($past(i_reg_rd && i_reg_addr == REG_UNLOCK) |->
    o_reg_rdata == 8'h00) else $error("unlock register read not zero");
  a_high_bits: assert property ($past(i_reg_rd && i_reg_addr == REG_ADDR_HIGH) |->
    o_reg_rdata[7:2] == 6'h00) else $error("address high spare bits set");
  a_ctrl_bits: assert property ($past(i_reg_rd && i_reg_addr == REG_CONTROL) |->
    o_reg_rdata[7:3] == 5'h00 && !o_reg_rdata[0] && o_reg_rdata[1] == $past(o_busy))
    else $error("control read mismatch");
  a_serial_gate: assert property (o_serial_wr_allow == exp_allow)
    else $error("serial write permission wrong");
  a_erase_row: assert property (o_fl_erase |->
    o_fl_addr[3:0] == ROW_BASE_LOW && o_core_stall) else $error("erase not at row base");
  a_erase_len: assert property ($rose(o_fl_erase) |->
    (o_fl_erase throughout ##EM1 1'b1) ##1 s_prog_run ##1 !o_fl_prog)
    else $error("erase then program run wrong");
  a_start_cause: assert property ($rose(o_busy) |->
    $past(i_reg_wr && i_reg_addr == REG_CONTROL && i_reg_wdata[CTRL_WR_BIT]))
    else $error("busy without start write");
  a_setup_two: assert property ($rose(o_busy) |-> s_setup ##1 (!o_busy || o_core_stall))
    else $error("setup cycles wrong");
  a_stall_busy: assert property (o_core_stall |-> o_busy)
    else $error("stall without busy");
  a_stall_end: assert property ($fell(o_core_stall) |-> $fell(o_busy))
    else $error("busy not cleared at end of stall");
endmodule : fswsq_chk

bind fswsq_top fswsq_chk #(.P_ERASE_CYC(P_ERASE_CYC)) u_chk (
  .i_clk(i_clk), .i_rstn(i_rstn), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
  .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata),
  .i_wrt_cfg(i_wrt_cfg), .i_serial_addr(i_serial_addr),
  .o_serial_wr_allow(o_serial_wr_allow), .o_core_stall(o_core_stall), .o_busy(o_busy),
  .o_fl_erase(o_fl_erase), .o_fl_prog(o_fl_prog), .o_fl_addr(o_fl_addr));

/* verification/fswsq_flash_model.sv */
// Flash array model behind the sequencer's erase and program port.
// Assumes erase and program levels sampled on the rising clock edge.
`timescale 1ns/1ps
module fswsq_flash_model (
  input  wire logic                         i_clk,
  input  wire logic                         i_erase,
  input  wire logic                         i_prog,
  input  wire logic [fswsq_pkg::ADDR_W-1:0] i_addr,
  input  wire logic [fswsq_pkg::DATA_W-1:0] i_data,
  output logic                              o_err
);
  import fswsq_pkg::*;
  // ****************************************************************
  // Array
  // ****************************************************************
  // Cells start unerased so a program without erase is caught
  logic [DATA_W-1:0] mem [1024];
  initial begin
    o_err = 1'b0;
    foreach (mem[i]) mem[i] = 14'h0000;
  end
  always @(posedge i_clk) begin
    if (i_erase === 1'b1) begin
      if (i_addr[3:0] !== 4'h0) o_err <= 1'b1;
      for (int i = 0; i < 16; i++) mem[{i_addr[9:4], 4'(i)}] <= 14'h3fff;
    end
    if (i_prog === 1'b1) begin
      if (mem[i_addr] !== 14'h3fff) o_err <= 1'b1;
      mem[i_addr] <= i_data;
    end
  end
endmodule : fswsq_flash_model

/* verification/testbench.sv */
// Self-checking bench of the flash self-write sequencer.
// Assumes the checker is bound and the flash model sits on the program port.
`timescale 1ns/1ps
module testbench;
  import fswsq_pkg::*;
  localparam int unsigned ERASE_N = 5;
  localparam int unsigned PWRT_N  = 40;
  localparam logic [7:0]  MASK [4] = '{8'hff, 8'h03, 8'hff, 8'h3f};
  logic              i_clk, i_rstn, i_ce, i_reg_wr, i_reg_rd, rd_d, fl_err;
  logic              o_serial_wr_allow, o_core_stall, o_busy, o_fl_erase, o_fl_prog;
  logic [2:0]        i_reg_addr;
  logic [7:0]        i_reg_wdata, o_reg_rdata, v;
  logic [1:0]        i_wrt_cfg;
  logic [ADDR_W-1:0] i_serial_addr, o_fl_addr, base;
  logic [DATA_W-1:0] o_fl_data;
  logic [7:0]        rq [$];
  logic [23:0]       pq [$];
  int                err_count, n_compared, seed;

  fswsq_top #(.P_ERASE_CYC(ERASE_N), .P_PWRT_CYC(PWRT_N)) DUT (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_ce(i_ce), .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
    .o_reg_rdata(o_reg_rdata), .i_wrt_cfg(i_wrt_cfg), .i_serial_addr(i_serial_addr),
    .o_serial_wr_allow(o_serial_wr_allow), .o_core_stall(o_core_stall), .o_busy(o_busy),
    .o_fl_erase(o_fl_erase), .o_fl_prog(o_fl_prog), .o_fl_addr(o_fl_addr),
    .o_fl_data(o_fl_data));
  fswsq_flash_model u_flash (.i_clk(i_clk), .i_erase(o_fl_erase), .i_prog(o_fl_prog),
    .i_addr(o_fl_addr), .i_data(o_fl_data), .o_err(fl_err));

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic end_sim();
    $display("Compared %0d, errors %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_sim
  task automatic tally(input bit ok, input logic [23:0] e, input logic [23:0] g);
    n_compared++;
    if (!ok) begin
      err_count++;
      $display("wrong value at %0t: expected %h got %h", $time, e, g);
    end
  endtask : tally
  task automatic cmp_rd(input logic [7:0] e, input logic [7:0] g);
    tally(g === e, {16'h0, e}, {16'h0, g});
  endtask : cmp_rd
  task automatic cmp_fl(input logic [23:0] e, input logic [23:0] g);
    tally(g === e, e, g);
  endtask : cmp_fl
  task automatic cyc(input logic w, input logic r, input logic [2:0] a, input logic [7:0] d);
    i_reg_wr <= w;
    i_reg_rd <= r;
    i_reg_addr <= a;
    i_reg_wdata <= d;
    @(posedge i_clk);
  endtask : cyc
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    cyc(1'b1, 1'b0, a, d);
  endtask : wr
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    rq.push_back(e);
    cyc(1'b0, 1'b1, a, 8'h00);
  endtask : rd
  task automatic wait_idle();
    int n;
    n = 0;
    while (o_busy !== 1'b0 && n < 100) begin
      @(posedge i_clk);
      n++;
    end
    if (n == 100) begin
      err_count++;
      end_sim();
    end
  endtask : wait_idle
  // One word: load, enable, unlock pair, start, control read, one idle slot
  task automatic wword(input logic [9:0] a, input logic [13:0] d, input logic [7:0] k,
                       input logic [7:0] ctl, input bit ok);
    wr(REG_ADDR_LOW, a[7:0]);
    wr(REG_ADDR_HIGH, {6'h0, a[9:8]});
    wr(REG_DATA_LOW, d[7:0]);
    wr(REG_DATA_HIGH, {2'h0, d[13:8]});
    wr(REG_CONTROL, ctl);
    wr(REG_UNLOCK, UNLOCK_FIRST);
    wr(REG_UNLOCK, k);
    wr(REG_CONTROL, ctl | 8'h02);
    rd(REG_CONTROL, {5'h0, ctl[2], ok, 1'b0});
    cyc(1'b0, 1'b0, REG_CONTROL, 8'h00);
    wait_idle();
  endtask : wword
  // Whole block in ascending order; only the last word commits
  task automatic blk(input logic [9:0] b, input bit ok);
    logic [13:0] d [4];
    foreach (d[i]) d[i] = 14'($random(seed));
    for (int i = 0; i < 4; i++) begin
      if (i == 3 && ok) for (int j = 0; j < 4; j++) pq.push_back({b[9:2], 2'(j), d[j]});
      wword({b[9:2], 2'(i)}, d[i], UNLOCK_SECOND, 8'h04, 1'b1);
    end
  endtask : blk

  // ****************************************************************
  // Stimulus and watcher
  // ****************************************************************
  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end
  always @(posedge i_clk) i_serial_addr <= 10'($random(seed));
  always @(posedge i_clk) begin
    if (rd_d === 1'b1) cmp_rd(rq.pop_front(), o_reg_rdata);
    if (o_fl_prog === 1'b1) begin
      if (pq.size() == 0) tally(1'b0, 24'h0, {o_fl_addr, o_fl_data});
      else cmp_fl(pq.pop_front(), {o_fl_addr, o_fl_data});
    end
    rd_d <= i_reg_rd;
  end
  initial begin
    seed = 57;
    err_count = 0;
    n_compared = 0;
    {i_rstn, i_reg_wr, i_reg_rd, i_reg_addr, i_reg_wdata} = '0;
    i_ce = 1'b1;
    i_wrt_cfg = 2'h3;
    repeat (12) @(posedge i_clk);
    i_rstn <= 1'b1;
    repeat (3) @(posedge i_clk);
    rd(REG_CONTROL, 8'h00);
    rd(REG_UNLOCK, 8'h00);
    wword(10'h3ff, 14'h1234, UNLOCK_SECOND, 8'h04, 1'b0);
    for (int k = 0; k < 4; k++) begin
      i_wrt_cfg <= 2'(k);
      v = 8'($random(seed));
      wr(3'(REG_ADDR_LOW + k), v);
      rd(3'(REG_ADDR_LOW + k), v & MASK[k]);
      rd(3'(6 + k[0]), 8'h00);
    end
    cyc(1'b0, 1'b0, REG_CONTROL, 8'h00);
    repeat (PWRT_N) @(posedge i_clk);
    i_wrt_cfg <= WRT_HALF;
    base = {1'b1, 9'($random(seed))} & 10'h3f0;
    for (int b = 0; b < 4; b++) blk(base + 10'(4 * b), 1'b1);
    blk(10'h1f4, 1'b0);
    wword(10'h3ff, 14'h0, 8'h12, 8'h04, 1'b0);
    wword(10'h3ff, 14'h0, UNLOCK_SECOND, 8'h00, 1'b0);
    // Enable low: the write must not land
    i_ce <= 1'b0;
    wr(REG_ADDR_LOW, 8'h00);
    i_ce <= 1'b1;
    rd(REG_ADDR_LOW, 8'hff);
    cyc(1'b0, 1'b0, REG_CONTROL, 8'h00);
    repeat (4) @(posedge i_clk);
    tally(pq.size() == 0, 24'h0, 24'(pq.size()));
    cmp_rd(8'h00, {7'h0, fl_err});
    end_sim();
  end
endmodule : testbench
